/* File: ldssc_pkg.sv */
// Shared constants and types of the LED driver serial port and its host
package ldssc_pkg;

    // ------------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------------
    localparam int unsigned CMD_W      = 16;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned ADDR_W     = 5;
    localparam int unsigned ADDR_LSB   = 8;
    localparam int unsigned ADDR_MSB   = 12;
    localparam int unsigned BIT_ZERO   = 13;
    localparam int unsigned BIT_RW     = 14;
    localparam int unsigned CNT_W      = 5;
    localparam logic [4:0]  WR_BITS    = 5'h10;
    localparam logic [4:0]  RD_BITS    = 5'h08;
    localparam logic [4:0]  CNT_MAX    = 5'h1F;
    localparam int unsigned NUM_REGS   = 32;
    localparam int unsigned NUM_DIGITS = 8;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_NOOP      = 5'h00;
    localparam logic [4:0] ADDR_DIGIT0    = 5'h01;
    localparam logic [4:0] ADDR_DECODE    = 5'h09;
    localparam logic [4:0] ADDR_INTENSITY = 5'h0A;
    localparam logic [4:0] ADDR_SCAN      = 5'h0B;
    localparam logic [4:0] ADDR_SHUTDOWN  = 5'h0C;
    localparam logic [4:0] ADDR_UNUSED    = 5'h0D;
    localparam logic [4:0] ADDR_FEATURE   = 5'h0E;
    localparam logic [4:0] ADDR_TEST      = 5'h0F;
    localparam logic [4:0] ADDR_LAST_WR   = 5'h13;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned SHDN_NORMAL_BIT = 0;
    localparam int unsigned SHDN_KEEP_BIT   = 7;
    localparam logic [7:0]  SHDN_MASK       = 8'h81;
    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam logic [7:0]  FEATURE_RESET   = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned SYS_PERIOD_NS = 25;
    localparam int unsigned HALF_NS       = 200;
    localparam int unsigned HALF_CYC_I    =
        (HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [3:0]  HALF_CYC      = HALF_CYC_I[3:0];

    // ------------------------------------------------------------------
    // Host sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FALL  = 3'b001,
        ST_LO    = 3'b010,
        ST_HI    = 3'b011,
        ST_RISE  = 3'b100,
        ST_RD_LO = 3'b101,
        ST_RD_HI = 3'b110,
        ST_END   = 3'b111
    } ldssc_state_t;

endpackage : ldssc_pkg

/* File: ldssc_if.sv */
// Serial link between the LED driver port and its host
`timescale 1ns/100ps
interface ldssc_if;
    logic shift_clk;
    logic load_strobe;
    logic serial_data_in;
    logic serial_data_out;

    modport dev (
        input  shift_clk,
        input  load_strobe,
        input  serial_data_in,
        output serial_data_out
    );

    modport host (
        output shift_clk,
        output load_strobe,
        output serial_data_in,
        input  serial_data_out
    );
endinterface : ldssc_if

/* File: ldssc_dev.sv */
// Device end: serial command port, register file and shutdown control
//
// Functional notes
// - Sample serial input on shift clock rise
// - Strobe fall starts access, rise commits it
// - Host clocks sixteen write or eight read bits
// - Data 0-7, address 8-12, 13 zero, 14 read
// - Bit 0 or bit 8 first, bit 15 last
// - Read data MSB first after strobe rise
// - Host keeps strobe high while reading data
// - Reset clears registers, blanks, enters shutdown
// - Host programs all registers after power-up; ldssc_host only sends the one access requested on i_start
// - Defaults: one digit, no decode, minimum intensity
// - Shutdown switches off all segment and digit drivers
// - Digit registers kept during shutdown
// - Shutdown write with bit7 low clears feature
// - Shutdown write with bit7 high keeps feature
// - External clock: host sets bit7 on shutdown writes
// - Shutdown register at 0x0C, codes 00/01/80/81
// - Shutdown bit0 selects normal, bits 6-1 ignored
`timescale 1ns/100ps
module ldssc_dev (
    // System
    input  wire logic                i_sys_clk,
    input  wire logic                i_rst,
    // Serial link
    ldssc_if.dev                     link,
    // Display control
    output logic                     o_normal_op,
    output logic                     o_drivers_off,
    output logic [7:0]               o_decode_en,
    output logic [7:0]               o_intensity,
    output logic [7:0]               o_scan_limit,
    output logic [7:0]               o_feature,
    output logic [7:0]               o_test_mode,
    output logic [63:0]              o_digits,
    // Write notification
    output logic                     o_wr_pulse,
    output logic [4:0]               o_wr_addr,
    output logic [7:0]               o_wr_data
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [2:0] clk_sync_r;
    logic [2:0] ld_sync_r;
    logic [1:0] sdi_sync_r;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            clk_sync_r <= 3'h0;
            ld_sync_r  <= 3'h7;
            sdi_sync_r <= 2'h0;
        end else begin
            clk_sync_r <= {clk_sync_r[1:0], link.shift_clk};
            ld_sync_r  <= {ld_sync_r[1:0], link.load_strobe};
            sdi_sync_r <= {sdi_sync_r[0], link.serial_data_in};
        end
    end

    wire sclk_rise = clk_sync_r[1] & ~clk_sync_r[2];
    wire ld_fall   = ~ld_sync_r[1] & ld_sync_r[2];
    wire ld_rise   = ld_sync_r[1] & ~ld_sync_r[2];
    wire ld_low    = ~ld_sync_r[1];
    wire sdi_bit   = sdi_sync_r[1];

    // ------------------------------------------------------------------
    // Command shifter
    // ------------------------------------------------------------------
    logic [15:0] shift_r;
    logic [15:0] shift_nxt;
    logic [4:0]  cnt_r;
    logic [4:0]  cnt_nxt;

    // Bits enter at the top and move down, so bit 0 ends in place
    wire shift_en = sclk_rise & ld_low;
    wire cnt_sat  = (cnt_r == ldssc_pkg::CNT_MAX);

    assign shift_nxt = shift_en ? {sdi_bit, shift_r[15:1]}
                                : shift_r;
    assign cnt_nxt   = ld_fall  ? 5'h00 :
                       (shift_en & ~cnt_sat) ? cnt_r + 5'h01 :
                       cnt_r;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_r <= 16'h0000;
            cnt_r   <= 5'h00;
        end else begin
            shift_r <= shift_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    wire [4:0] cmd_addr = shift_r[ldssc_pkg::ADDR_MSB:ldssc_pkg::ADDR_LSB];
    wire [7:0] cmd_data = shift_r[7:0];
    wire       cmd_rd   = shift_r[ldssc_pkg::BIT_RW];
    wire       cmd_z_ok = ~shift_r[ldssc_pkg::BIT_ZERO];

    wire wr_commit = ld_rise & cmd_z_ok & ~cmd_rd &
                     (cnt_r == ldssc_pkg::WR_BITS);
    wire rd_commit = ld_rise & cmd_z_ok & cmd_rd &
                     (cnt_r == ldssc_pkg::RD_BITS);

    wire addr_wr_ok = (cmd_addr != ldssc_pkg::ADDR_NOOP) &
                      (cmd_addr != ldssc_pkg::ADDR_UNUSED) &
                      (cmd_addr <= ldssc_pkg::ADDR_LAST_WR);
    wire wr_en      = wr_commit & addr_wr_ok;
    wire shdn_wr    = wr_en & (cmd_addr == ldssc_pkg::ADDR_SHUTDOWN);
    // Feature cleared on any shutdown write with the keep bit low
    wire feat_clr   = shdn_wr &
                      ~cmd_data[ldssc_pkg::SHDN_KEEP_BIT];
    wire [7:0] shdn_val = cmd_data & ldssc_pkg::SHDN_MASK;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] regs_r [0:ldssc_pkg::NUM_REGS-1];

    genvar gi;
    generate
        for (gi = 0; gi < ldssc_pkg::NUM_REGS; gi++) begin : g_reg
            localparam logic [4:0] IDX = 5'(gi);
            wire hit  = wr_en & (cmd_addr == IDX);
            wire clr  = feat_clr & (IDX == ldssc_pkg::ADDR_FEATURE);
            wire [7:0] wval = (IDX == ldssc_pkg::ADDR_SHUTDOWN) ?
                              shdn_val : cmd_data;
            // All defaults are zero: shutdown, one digit, no decode
            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    regs_r[gi] <= ldssc_pkg::REG_RESET;
                end else if (hit) begin
                    regs_r[gi] <= wval;
                end else if (clr) begin
                    regs_r[gi] <= ldssc_pkg::FEATURE_RESET;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read-back shifter
    // ------------------------------------------------------------------
    logic [7:0] rd_sh_r;
    logic [7:0] rd_sh_nxt;
    logic [3:0] rd_cnt_r;
    logic [3:0] rd_cnt_nxt;
    logic       rd_act_r;
    logic       rd_act_nxt;
    logic       sdo_r;
    logic       sdo_nxt;

    // Output moves only while the strobe stays high after the command
    wire rd_step = rd_act_r & sclk_rise & ~ld_low;

    assign rd_act_nxt = rd_commit ? 1'b1 :
                        (ld_fall | (rd_step & rd_cnt_r == 4'h7)) ? 1'b0 :
                        rd_act_r;
    assign rd_sh_nxt  = rd_commit ? regs_r[cmd_addr] :
                        rd_step   ? {rd_sh_r[6:0], 1'b0} :
                        rd_sh_r;
    assign rd_cnt_nxt = rd_commit ? 4'h0 :
                        rd_step   ? rd_cnt_r + 4'h1 :
                        rd_cnt_r;
    assign sdo_nxt    = rd_step ? rd_sh_r[7] : sdo_r;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_sh_r  <= 8'h00;
            rd_cnt_r <= 4'h0;
            rd_act_r <= 1'b0;
            sdo_r    <= 1'b0;
        end else begin
            rd_sh_r  <= rd_sh_nxt;
            rd_cnt_r <= rd_cnt_nxt;
            rd_act_r <= rd_act_nxt;
            sdo_r    <= sdo_nxt;
        end
    end

    assign link.serial_data_out = sdo_r;

    // ------------------------------------------------------------------
    // Write notification
    // ------------------------------------------------------------------
    logic       wr_pulse_r;
    logic [4:0] wr_addr_r;
    logic [7:0] wr_data_r;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_pulse_r <= 1'b0;
            wr_addr_r  <= 5'h00;
            wr_data_r  <= 8'h00;
        end else begin
            wr_pulse_r <= wr_en;
            wr_addr_r  <= wr_en ? cmd_addr : wr_addr_r;
            wr_data_r  <= wr_en ? cmd_data : wr_data_r;
        end
    end

    // ------------------------------------------------------------------
    // Display control outputs
    // ------------------------------------------------------------------
    wire [7:0] shdn_reg = regs_r[ldssc_pkg::ADDR_SHUTDOWN];

    assign o_normal_op   = shdn_reg[ldssc_pkg::SHDN_NORMAL_BIT];
    assign o_drivers_off = ~shdn_reg[ldssc_pkg::SHDN_NORMAL_BIT];
    assign o_decode_en   = regs_r[ldssc_pkg::ADDR_DECODE];
    assign o_intensity   = regs_r[ldssc_pkg::ADDR_INTENSITY];
    assign o_scan_limit  = regs_r[ldssc_pkg::ADDR_SCAN];
    assign o_feature     = regs_r[ldssc_pkg::ADDR_FEATURE];
    assign o_test_mode   = regs_r[ldssc_pkg::ADDR_TEST];
    assign o_wr_pulse    = wr_pulse_r;
    assign o_wr_addr     = wr_addr_r;
    assign o_wr_data     = wr_data_r;

    // Digit contents are untouched by shutdown
    generate
        for (gi = 0; gi < ldssc_pkg::NUM_DIGITS; gi++) begin : g_dig
            assign o_digits[gi*8 +: 8] =
                regs_r[ldssc_pkg::ADDR_DIGIT0 + gi];
        end
    endgenerate

endmodule : ldssc_dev

/* File: ldssc_host.sv */
// Host end: issues write and read accesses over the serial link
`timescale 1ns/100ps
module ldssc_host (
    // System
    input  wire logic                i_sys_clk,
    input  wire logic                i_rst,
    // Serial link
    ldssc_if.host                    link,
    // Command port
    input  wire logic                i_start,
    input  wire logic                i_read,
    input  wire logic [4:0]          i_addr,
    input  wire logic [7:0]          i_wdata,
    output logic                     o_busy,
    output logic                     o_done,
    output logic [7:0]               o_rdata
);

    // ------------------------------------------------------------------
    // Read data synchroniser
    // ------------------------------------------------------------------
    logic [1:0] sdo_sync_r;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sdo_sync_r <= 2'h0;
        end else begin
            sdo_sync_r <= {sdo_sync_r[0], link.serial_data_out};
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    ldssc_pkg::ldssc_state_t st_r;
    ldssc_pkg::ldssc_state_t st_nxt;
    logic [3:0]  tmr_r;
    logic [4:0]  bit_r;
    logic [15:0] word_r;
    logic        rd_r;
    logic        sclk_r;
    logic        ld_r;
    logic        sdi_r;
    logic        done_r;
    logic [7:0]  rdata_r;

    wire       tmr_end  = (tmr_r == ldssc_pkg::HALF_CYC - 4'h1);
    // Write sends bits 0..15, read sends bits 8..15 only
    wire [4:0] bit_last = rd_r ? 5'h07 : 5'h0F;
    wire [15:0] cmd_word = {1'b0, i_read, 1'b0, i_addr, i_wdata};
    wire [3:0] bit_idx  = rd_r ? bit_r[3:0] + 4'h8 : bit_r[3:0];

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ldssc_pkg::ST_IDLE: if (i_start) st_nxt = ldssc_pkg::ST_FALL;
            ldssc_pkg::ST_FALL: if (tmr_end) st_nxt = ldssc_pkg::ST_LO;
            ldssc_pkg::ST_LO:   if (tmr_end) st_nxt = ldssc_pkg::ST_HI;
            ldssc_pkg::ST_HI: begin
                if (tmr_end) begin
                    st_nxt = (bit_r == bit_last) ? ldssc_pkg::ST_RISE
                                                 : ldssc_pkg::ST_LO;
                end
            end
            ldssc_pkg::ST_RISE: begin
                if (tmr_end) begin
                    st_nxt = rd_r ? ldssc_pkg::ST_RD_LO
                                  : ldssc_pkg::ST_END;
                end
            end
            ldssc_pkg::ST_RD_LO: if (tmr_end) st_nxt = ldssc_pkg::ST_RD_HI;
            ldssc_pkg::ST_RD_HI: begin
                if (tmr_end) begin
                    st_nxt = (bit_r == 5'h07) ? ldssc_pkg::ST_END
                                              : ldssc_pkg::ST_RD_LO;
                end
            end
            ldssc_pkg::ST_END: st_nxt = ldssc_pkg::ST_IDLE;
            default:  st_nxt = ldssc_pkg::ST_IDLE;
        endcase
    end

    wire state_chg = (st_nxt != st_r);
    wire hi_end    = tmr_end & ((st_r == ldssc_pkg::ST_HI) |
                                (st_r == ldssc_pkg::ST_RD_HI));

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r    <= ldssc_pkg::ST_IDLE;
            tmr_r   <= 4'h0;
            bit_r   <= 5'h00;
            word_r  <= 16'h0000;
            rd_r    <= 1'b0;
            rdata_r <= 8'h00;
            done_r  <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            tmr_r  <= state_chg ? 4'h0 : tmr_r + 4'h1;
            done_r <= (st_r == ldssc_pkg::ST_END);
            if (st_r == ldssc_pkg::ST_IDLE && i_start) begin
                word_r <= cmd_word;
                rd_r   <= i_read;
                bit_r  <= 5'h00;
            end else if (st_r == ldssc_pkg::ST_RISE) begin
                bit_r  <= 5'h00;
            end else if (hi_end) begin
                bit_r  <= bit_r + 5'h01;
            end
            // Sample late in the high phase, after the device has moved
            if (tmr_end && st_r == ldssc_pkg::ST_RD_HI) begin
                rdata_r <= {rdata_r[6:0], sdo_sync_r[1]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    wire st_low  = (st_r == ldssc_pkg::ST_FALL) |
                   (st_r == ldssc_pkg::ST_LO) |
                   (st_r == ldssc_pkg::ST_HI);
    wire st_sclk = (st_r == ldssc_pkg::ST_HI) |
                   (st_r == ldssc_pkg::ST_RD_HI);

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sclk_r <= 1'b0;
            ld_r   <= 1'b1;
            sdi_r  <= 1'b0;
        end else begin
            sclk_r <= st_sclk;
            ld_r   <= ~st_low;
            sdi_r  <= st_low ? word_r[bit_idx] : 1'b0;
        end
    end

    assign link.shift_clk      = sclk_r;
    assign link.load_strobe    = ld_r;
    assign link.serial_data_in = sdi_r;
    assign o_busy  = (st_r != ldssc_pkg::ST_IDLE);
    assign o_done  = done_r;
    assign o_rdata = rdata_r;

endmodule : ldssc_host

/* File: ldssc_asserts.sv */
// Checker of the serial link between the host and the device port
`timescale 1ns/100ps
module ldssc_asserts (
    // System
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    // Serial link
    input  wire logic shift_clk,
    input  wire logic load_strobe,
    input  wire logic serial_data_in,
    input  wire logic serial_data_out
);
    // ------------------------------------------------------------------
    // Bits per frame and cycles since the last shift rise
    // ------------------------------------------------------------------
    logic [5:0] bits_r;
    logic [3:0] since_r;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            bits_r <= 6'h00;
        end else if ($fell(load_strobe)) begin
            bits_r <= 6'h00;
        end else if (!load_strobe && $rose(shift_clk)) begin
            bits_r <= bits_r + 6'h01;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            since_r <= 4'hF;
        end else if ($rose(shift_clk)) begin
            since_r <= 4'h0;
        end else if (since_r != 4'hF) begin
            since_r <= since_r + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_lead;
        !shift_clk[*8] ##[1:12] $rose(shift_clk);
    endsequence
    sequence s_read_end;
        $rose(load_strobe) && bits_r == 6'h08;
    endsequence

    a_fall_clk_low: assert property ($fell(load_strobe) |-> !shift_clk)
        else $error("shift clock high at strobe fall");
    a_rise_clk_low: assert property ($rose(load_strobe) |-> !shift_clk)
        else $error("shift clock high at strobe rise");
    a_first_bit_lead: assert property ($fell(load_strobe) |-> s_lead)
        else $error("first shift rise not after strobe setup");
    a_data_held_rise: assert property ($rose(shift_clk)
        |-> $stable(serial_data_in))
        else $error("serial input moved at shift rise");
    a_high_phase_len: assert property ($rose(shift_clk)
        |=> shift_clk[*7])
        else $error("shift clock high phase too short");
    a_low_phase_len: assert property ($fell(shift_clk)
        |=> !shift_clk[*7])
        else $error("shift clock low phase too short");
    a_frame_bit_count: assert property ($rose(load_strobe)
        |-> bits_r == 6'h10 || bits_r == 6'h08)
        else $error("frame bit count not 16 or 8");
    a_read_strobe_held: assert property (s_read_end
        |-> load_strobe throughout (##120 1'b1))
        else $error("strobe dropped during read out");
    a_out_after_rise: assert property ($changed(serial_data_out)
        |-> since_r <= 4'h6)
        else $error("serial output moved away from a shift rise");
endmodule : ldssc_asserts

/* File: ldssc_tb.sv */
// Testbench: host and device ends joined, plus a device driven directly
`timescale 1ns/100ps
module ldssc_tb;
    logic        sys_clk, rst, start, rd, busy, done, wr_pulse;
    logic [4:0]  addr, wr_addr, last_a;
    logic [7:0]  wdata, rdata, dec, inten, scan, feat, tmode, last_d;
    logic [7:0]  wr_data;
    logic        normal_op, drv_off, b_normal;
    logic [63:0] digits;
    logic [7:0]  regs [32];
    int          failures, n_tests, cycles, pulses, n_wr;
    int unsigned seed;

    ldssc_if link ();
    ldssc_if link_b ();
    ldssc_host u_ldssc_host (.i_sys_clk(sys_clk), .i_rst(rst), .link(link),
        .i_start(start), .i_read(rd), .i_addr(addr), .i_wdata(wdata),
        .o_busy(busy), .o_done(done), .o_rdata(rdata));
    ldssc_dev u_ldssc_dev (.i_sys_clk(sys_clk), .i_rst(rst), .link(link),
        .o_normal_op(normal_op), .o_drivers_off(drv_off), .o_decode_en(dec),
        .o_intensity(inten), .o_scan_limit(scan), .o_feature(feat),
        .o_test_mode(tmode), .o_digits(digits), .o_wr_pulse(wr_pulse),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data));
    ldssc_dev u_ldssc_dev_b (.i_sys_clk(sys_clk), .i_rst(rst), .link(link_b),
        .o_normal_op(b_normal), .o_drivers_off(), .o_decode_en(),
        .o_intensity(), .o_scan_limit(), .o_feature(), .o_test_mode(),
        .o_digits(), .o_wr_pulse(), .o_wr_addr(), .o_wr_data());
    ldssc_asserts u_ldssc_asserts (.i_sys_clk(sys_clk), .i_rst(rst),
        .shift_clk(link.shift_clk), .load_strobe(link.load_strobe),
        .serial_data_in(link.serial_data_in),
        .serial_data_out(link.serial_data_out));

    // ------------------------------------------------------------------
    // Clock, timeout and pulse count
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (wr_pulse === 1'b1) pulses++;
        if (cycles == 40000) begin
            failures++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Model, checks and drivers
    // ------------------------------------------------------------------
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic void mdl_wr(input logic [4:0] a, input logic [7:0] d);
        if (a == 5'h00 || a == 5'h0D || a > 5'h13) return;
        n_wr++;
        last_a = a;
        last_d = d;
        if (a != 5'h0C) regs[a] = d;
        else regs[a] = d & 8'h81;
        if (a == 5'h0C && !d[7]) regs[5'h0E] = 8'h00;
    endfunction : mdl_wr

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic check_all;
        logic [63:0] dig;
        for (int k = 0; k < 8; k++) dig[8*k +: 8] = regs[k+1];
        chk(normal_op, regs[5'h0C][0]);
        chk(drv_off, !regs[5'h0C][0]);
        chk(dec, regs[5'h09]);
        chk(inten, regs[5'h0A]);
        chk(scan, regs[5'h0B]);
        chk(feat, regs[5'h0E]);
        chk(tmode, regs[5'h0F]);
        chk(digits, dig);
        chk(wr_addr, last_a);
        chk(wr_data, last_d);
        chk(pulses, n_wr);
    endtask : check_all

    task automatic acc(input logic r, input logic [4:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        start <= 1'b1;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        start <= 1'b0;
        #1;
        chk(busy, 1'b1);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 400);
        if (n >= 400) begin
            failures++;
            $display("Error at %0t: access never completed", $time);
        end
        chk(busy, 1'b0);
        repeat (4) @(posedge sys_clk);
    endtask : acc

    // Direct frame of n bits into the second device, 200 ns link period
    // For n of sixteen or more, the last sixteen bits sent form the word w
    task automatic frame(input int n, input logic [15:0] w);
        @(posedge sys_clk);
        link_b.load_strobe <= 1'b0;
        for (int i = 0; i < n; i++) begin
            link_b.serial_data_in <= w[(i + 32 - n) % 16];
            repeat (4) @(posedge sys_clk);
            link_b.shift_clk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            link_b.shift_clk <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        link_b.load_strobe <= 1'b1;
        link_b.serial_data_in <= ~link_b.serial_data_in;
        repeat (16) @(posedge sys_clk);
    endtask : frame

    task automatic results;
        $display("TB: tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [4:0] a;
        logic [7:0] d;
        logic [7:0] codes [4];
        codes = '{8'h00, 8'h01, 8'h80, 8'h81};
        seed = 92626;
        rst = 1'b1;
        start = 1'b0;
        rd = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
        link_b.shift_clk = 1'b0;
        link_b.load_strobe = 1'b1;
        link_b.serial_data_in = 1'b0;
        foreach (regs[k]) regs[k] = 8'h00;
        last_a = 5'h00;
        last_d = 8'h00;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check_all();
        $display("TB: reset defaults done");
        for (int i = 0; i < 12; i++) begin
            a = 5'(xs());
            d = 8'(xs());
            acc(1'b0, a, d);
            mdl_wr(a, d);
            check_all();
            a = 5'(xs());
            acc(1'b1, a, 8'h00);
            chk(rdata, regs[a]);
        end
        $display("TB: random write and read done");
        foreach (codes[i]) begin
            acc(1'b0, 5'h0E, 8'h5A);
            mdl_wr(5'h0E, 8'h5A);
            d = codes[i] | (8'(xs()) & 8'h7E);
            acc(1'b0, 5'h0C, d);
            mdl_wr(5'h0C, d);
            check_all();
            acc(1'b1, 5'h0C, 8'h00);
            chk(rdata, codes[i]);
        end
        $display("TB: shutdown codes done");
        for (int n = 7; n <= 17; n += 2) begin
            if (n != 9) frame(n, 16'h0C01);
            chk(b_normal, 1'b0);
        end
        frame(16, 16'h2C01);
        chk(b_normal, 1'b0);
        frame(16, 16'h0C01);
        chk(b_normal, 1'b1);
        $display("TB: bit count frames done");
        results();
    end
endmodule : ldssc_tb
